//--- design/spl_program_latches.sv
`timescale 1ns/10ps
module spl_program_latches
(
    input  wire logic        i_mclk,
    input  wire logic        i_rst_n,
    input  wire logic        i_sclk,
    input  wire logic        i_sdata,
    input  wire logic        i_latch_load_strobe,
    input  wire logic        i_chip_en,
    input  wire logic        i_ref_in,
    input  wire logic        i_vco_in,
    output logic             o_powered_down,
    output logic             o_pump_tristate,
    output logic             o_pump_gain_set2,
    output logic [2:0]       o_pump_current_code,
    output logic             o_detector_polarity,
    output logic             o_rf_enable,
    output logic             o_ref_buffer_en,
    output logic             o_lock,
    output logic             o_halver_en,
    output logic             o_presc_src_halved,
    output logic             o_ref_out,
    output logic             o_fb_out,
    output logic             o_band_tick,
    output logic [18:0]      o_feedback_ratio,
    output logic [1:0]       o_output_power_level,
    output logic [1:0]       o_core_current_level,
    output logic [2:0]       o_status_mux_select,
    output logic [1:0]       o_antibacklash_width
);

    // ------------------------------------------------------------
    // Serial input register
    // ------------------------------------------------------------
    spl_word_if wif ();

    spl_serial_in u_serial
    (
        .i_mclk              (i_mclk),
        .i_rst_n             (i_rst_n),
        .i_sclk              (i_sclk),
        .i_sdata             (i_sdata),
        .i_latch_load_strobe (i_latch_load_strobe),
        .wif                 (wif.src)
    );

    // ------------------------------------------------------------
    // Latches
    // ------------------------------------------------------------
    logic [23:0]       ctrl_latch;
    logic [23:0]       fb_latch;
    logic [23:0]       ref_latch;
    logic              pump_gain;
    logic              ld_ctrl;
    logic              ld_fb;
    logic              ld_ref;
    logic [1:0]        sel;

    assign sel = wif.word[1:0];
    assign ld_ctrl = wif.load && (sel == spl_pkg::SEL_CONTROL);
    assign ld_fb   = wif.load && (sel == spl_pkg::SEL_FEEDBACK);
    assign ld_ref  = wif.load && (sel == spl_pkg::SEL_REFERENCE);

    // Latch storage, written whatever the power state
    // Loads during power-down
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            ctrl_latch <= spl_pkg::CONTROL_RST;
            fb_latch   <= spl_pkg::FEEDBACK_RST;
            ref_latch  <= spl_pkg::REFERENCE_RST;
        end
        else
        begin
            if (ld_ctrl)
                ctrl_latch <= wif.word;
            if (ld_fb)
                fb_latch <= wif.word;
            if (ld_ref)
                ref_latch <= wif.word;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
            pump_gain <= 1'b0;
        else if (ld_ctrl)
            pump_gain <= wif.word[spl_pkg::CT_GAIN];
        else if (ld_fb)
            pump_gain <= wif.word[spl_pkg::FB_GAIN];
    end

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    logic [13:0] ref_div;
    logic [12:0] main_count;
    logic [4:0]  swallow_count;
    logic [5:0]  presc_mod;
    logic [1:0]  band_clock_divider;
    logic        cnt_reset;
    logic        mute;

    assign ref_div       = ref_latch[spl_pkg::RF_DIV_LSB +: spl_pkg::RF_DIV_W];
    assign main_count    = fb_latch[spl_pkg::FB_MAIN_LSB +: spl_pkg::FB_MAIN_W];
    assign swallow_count = fb_latch[spl_pkg::FB_SWALLOW_LSB +: spl_pkg::FB_SWALLOW_W];
    assign band_clock_divider = ref_latch[spl_pkg::RF_BAND_LSB +: 2];
    assign cnt_reset     = ctrl_latch[spl_pkg::CT_CNT_RST];
    assign mute          = ctrl_latch[spl_pkg::CT_MUTE];

    // Prescaler modulus from the two top control bits
    always_comb
    begin
        case (ctrl_latch[spl_pkg::CT_PRESC_LSB +: 2])
            2'h0:    presc_mod = spl_pkg::PRESC_MOD_8;
            2'h1:    presc_mod = spl_pkg::PRESC_MOD_16;
            default: presc_mod = spl_pkg::PRESC_MOD_32;
        endcase
    end

    assign o_feedback_ratio = 19'(presc_mod) * 19'(main_count) + 19'(swallow_count);

    // ------------------------------------------------------------
    // Power-down control
    // ------------------------------------------------------------
    spl_pkg::spl_pwr_e pwr_state;
    logic [1:0]        pd_edges;
    logic              ref_pulse;
    logic              pd;

    // Synchronous mode waits on the reference output to avoid frequency jumps
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            pwr_state <= spl_pkg::PWR_ON;
            pd_edges  <= 2'h0;
        end
        else if (ld_ctrl && !wif.word[spl_pkg::CT_PD_ARM])
            pwr_state <= spl_pkg::PWR_ON;
        else if (ld_ctrl && !wif.word[spl_pkg::CT_PD_SYNC])
            pwr_state <= spl_pkg::PWR_DOWN;
        else if (ld_ctrl)
        begin
            pwr_state <= spl_pkg::PWR_ARMED;
            pd_edges  <= 2'h0;
        end
        else
        begin
            case (pwr_state)
                spl_pkg::PWR_ON:   pwr_state <= spl_pkg::PWR_ON;
                spl_pkg::PWR_ARMED:
                begin
                    if (ref_pulse)
                    begin
                        pd_edges <= pd_edges + 2'h1;
                        if (pd_edges + 2'h1 == spl_pkg::SYNC_PD_EDGES)
                            pwr_state <= spl_pkg::PWR_DOWN;
                    end
                end
                spl_pkg::PWR_DOWN: pwr_state <= spl_pkg::PWR_DOWN;
                default:           pwr_state <= spl_pkg::PWR_ON;
            endcase
        end
    end

    assign pd = !i_chip_en || (pwr_state == spl_pkg::PWR_DOWN);

    // ------------------------------------------------------------
    // Reference and feedback counters
    // ------------------------------------------------------------
    logic        ref_q;
    logic        vco_q;
    logic        halve_q;
    logic        presc_tick;
    logic        fb_pulse;
    logic        hold;
    logic [13:0] ref_cnt;
    logic [18:0] fb_cnt;

    assign hold = pd || cnt_reset;

    // Input edge samples; pins are synchronous to i_mclk
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            ref_q <= 1'b0;
            vco_q <= 1'b0;
        end
        else
        begin
            ref_q <= i_ref_in;
            vco_q <= i_vco_in;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n || !fb_latch[spl_pkg::FB_HALVER])
            halve_q <= 1'b0;
        else if (i_vco_in && !vco_q)
            halve_q <= !halve_q;
    end

    always_comb
    begin
        if (fb_latch[spl_pkg::FB_PRESC_SRC])
            presc_tick = i_vco_in && !vco_q && !halve_q;
        else
            presc_tick = i_vco_in && !vco_q;
    end

    // Reference divider; a zero ratio behaves as one
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n || hold)
        begin
            ref_cnt   <= 14'h0000;
            ref_pulse <= 1'b0;
        end
        else
        begin
            ref_pulse <= 1'b0;
            if (i_ref_in && !ref_q)
            begin
                if (ref_cnt + 14'h0001 >= ref_div)
                begin
                    ref_cnt   <= 14'h0000;
                    ref_pulse <= 1'b1;
                end
                else
                    ref_cnt <= ref_cnt + 14'h0001;
            end
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n || hold)
        begin
            fb_cnt   <= 19'h00000;
            fb_pulse <= 1'b0;
        end
        else
        begin
            fb_pulse <= 1'b0;
            if (presc_tick)
            begin
                if (fb_cnt + 19'h00001 >= o_feedback_ratio)
                begin
                    fb_cnt   <= 19'h00000;
                    fb_pulse <= 1'b1;
                end
                else
                    fb_cnt <= fb_cnt + 19'h00001;
            end
        end
    end

    // ------------------------------------------------------------
    // Digital lock detect and band clock
    // ------------------------------------------------------------
    localparam int W = spl_pkg::LOCK_WINDOW_CYC;
    logic [W-1:0]   ref_hist;
    logic [2*W-1:0] fb_hist;
    logic [2:0]     lock_run;
    logic [2:0]     lock_need;
    logic           lock_q;
    logic           good;
    logic [2:0]     band_cnt;

    assign lock_need = ref_latch[spl_pkg::RF_LOCK_PREC] ? spl_pkg::LOCK_CNT_FINE
                                                       : spl_pkg::LOCK_CNT_BASE;
    assign good = fb_pulse || (|fb_hist);

    // Reference edge judged once the window after it has passed
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n || pd)
        begin
            ref_hist <= '0;
            fb_hist  <= '0;
            lock_run <= 3'h0;
            lock_q   <= 1'b0;
        end
        else
        begin
            // Oldest sample drops off the top of each history
            ref_hist <= W'({ref_hist, ref_pulse});
            fb_hist  <= (2*W)'({fb_hist, fb_pulse});
            if (ref_hist[W-1] && good)
            begin
                if (lock_run < lock_need)
                    lock_run <= lock_run + 3'h1;
                if (lock_run + 3'h1 >= lock_need)
                    lock_q <= 1'b1;
            end
            else if (ref_hist[W-1])
            begin
                lock_run <= 3'h0;
                lock_q   <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n || hold)
        begin
            band_cnt    <= 3'h0;
            o_band_tick <= 1'b0;
        end
        else
        begin
            o_band_tick <= 1'b0;
            if (ref_pulse)
            begin
                if (4'(band_cnt) + 4'h1 >= (4'h1 << band_clock_divider))
                begin
                    band_cnt    <= 3'h0;
                    o_band_tick <= 1'b1;
                end
                else
                    band_cnt <= band_cnt + 3'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign o_powered_down       = pd;
    assign o_pump_tristate      = pd || ctrl_latch[spl_pkg::CT_PUMP_TRI];
    assign o_pump_gain_set2     = pump_gain;
    assign o_pump_current_code  = pump_gain ? ctrl_latch[spl_pkg::CT_CUR2_LSB +: 3]
                                            : ctrl_latch[spl_pkg::CT_CUR1_LSB +: 3];
    assign o_detector_polarity  = ctrl_latch[spl_pkg::CT_POL];
    assign o_rf_enable          = !pd && (!mute || lock_q);
    assign o_ref_buffer_en      = !pd;
    assign o_lock               = lock_q && !pd;
    assign o_halver_en          = fb_latch[spl_pkg::FB_HALVER];
    assign o_presc_src_halved   = fb_latch[spl_pkg::FB_PRESC_SRC];
    assign o_ref_out            = ref_pulse;
    assign o_fb_out             = fb_pulse;
    assign o_output_power_level = ctrl_latch[spl_pkg::CT_PWR_LSB +: 2];
    assign o_core_current_level = ctrl_latch[spl_pkg::CT_CORE_LSB +: 2];
    assign o_status_mux_select  = ctrl_latch[spl_pkg::CT_MUX_LSB +: 3];
    assign o_antibacklash_width = ref_latch[spl_pkg::RF_ABP_LSB +: 2];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    sequence s_ctrl_load;
        ld_ctrl && wif.word[spl_pkg::CT_PD_ARM];
    endsequence

    sequence s_no_ctrl(n);
        !ld_ctrl [*1] ##0 (n == n);
    endsequence

    select_ctrl_a: assert property (
        ld_ctrl |=> ctrl_latch == $past(wif.word))
        else $error("control latch not loaded");

    async_pd_a: assert property (
        s_ctrl_load ##0 !wif.word[spl_pkg::CT_PD_SYNC] |=> o_powered_down)
        else $error("asynchronous power-down late");

    sync_pd_a: assert property (
        s_ctrl_load ##0 wif.word[spl_pkg::CT_PD_SYNC] ##1
        (i_chip_en && !ld_ctrl && !ref_pulse) |-> !o_powered_down)
        else $error("synchronous power-down too early");

    ce_off_a: assert property (
        !i_chip_en |-> o_powered_down && !o_rf_enable)
        else $error("chip enable low not honoured");

    pd_effects_a: assert property (
        o_powered_down |-> (o_pump_tristate && !o_ref_buffer_en && !o_rf_enable)
        ##1 (ref_cnt == 14'h0000 && fb_cnt == 19'h00000 && !lock_q))
        else $error("power-down side effects missing");

    gain_latest_a: assert property (
        ld_fb |=> o_pump_gain_set2 == $past(wif.word[spl_pkg::FB_GAIN]))
        else $error("gain not taken from feedback word");

    mute_lock_a: assert property (
        mute && !o_lock |-> !o_rf_enable)
        else $error("outputs on before lock");

    counter_hold_a: assert property (
        cnt_reset [*2] |-> ref_cnt == 14'h0000 && !fb_pulse)
        else $error("counters run during reset");

    lock_count_a: assert property (
        $rose(lock_q) |-> $past(lock_run) + 3'h1 >= $past(lock_need))
        else $error("lock declared too soon");

    test_ignore_a: assert property (
        wif.load && sel == spl_pkg::SEL_TEST |=>
        $stable(ctrl_latch) && $stable(fb_latch) && $stable(ref_latch))
        else $error("test word changed a latch");

endmodule : spl_program_latches

//--- design/spl_pkg.sv
package spl_pkg;

    // ------------------------------------------------------------
    // Word format and latch select codes
    // ------------------------------------------------------------
    localparam int         WORD_W        = 24;
    localparam logic [1:0] SEL_CONTROL   = 2'h0;
    localparam logic [1:0] SEL_REFERENCE = 2'h1;
    localparam logic [1:0] SEL_FEEDBACK  = 2'h2;
    localparam logic [1:0] SEL_TEST      = 2'h3;

    // ------------------------------------------------------------
    // Control latch fields
    // ------------------------------------------------------------
    localparam int CT_PRESC_LSB = 22;
    localparam int CT_PD_SYNC   = 21;
    localparam int CT_PD_ARM    = 20;
    localparam int CT_CUR2_LSB  = 17;
    localparam int CT_CUR1_LSB  = 14;
    localparam int CT_PWR_LSB   = 12;
    localparam int CT_MUTE      = 11;
    localparam int CT_GAIN      = 10;
    localparam int CT_PUMP_TRI  = 9;
    localparam int CT_POL       = 8;
    localparam int CT_MUX_LSB   = 5;
    localparam int CT_CNT_RST   = 4;
    localparam int CT_CORE_LSB  = 2;

    // ------------------------------------------------------------
    // Feedback and reference latch fields
    // ------------------------------------------------------------
    localparam int FB_PRESC_SRC   = 23;
    localparam int FB_HALVER      = 22;
    localparam int FB_GAIN        = 21;
    localparam int FB_MAIN_LSB    = 8;
    localparam int FB_MAIN_W      = 13;
    localparam int FB_SWALLOW_LSB = 2;
    localparam int FB_SWALLOW_W   = 5;
    localparam int FB_TOTAL_W     = 19;
    localparam int RF_BAND_LSB    = 20;
    localparam int RF_TEST        = 19;
    localparam int RF_LOCK_PREC   = 18;
    localparam int RF_ABP_LSB     = 16;
    localparam int RF_DIV_LSB     = 2;
    localparam int RF_DIV_W       = 14;

    // ------------------------------------------------------------
    // Reset values, moduli and counts
    // ------------------------------------------------------------
    localparam logic [23:0] CONTROL_RST   = 24'h000000;
    localparam logic [23:0] FEEDBACK_RST  = 24'h000000;
    localparam logic [23:0] REFERENCE_RST = 24'h000000;
    localparam logic [5:0]  PRESC_MOD_8   = 6'h08;
    localparam logic [5:0]  PRESC_MOD_16  = 6'h10;
    localparam logic [5:0]  PRESC_MOD_32  = 6'h20;
    localparam logic [2:0]  LOCK_CNT_FINE = 3'h5;
    localparam logic [2:0]  LOCK_CNT_BASE = 3'h3;
    localparam logic [1:0]  SYNC_PD_EDGES = 2'h2;
    localparam int CLK_PERIOD_NS  = 20;
    localparam int LOCK_WINDOW_NS = 15;
    localparam int LOCK_WINDOW_CYC =
        (LOCK_WINDOW_NS / CLK_PERIOD_NS < 1) ? 1 : LOCK_WINDOW_NS / CLK_PERIOD_NS;

    // Power state, one-hot
    typedef enum logic [2:0]
    {
        PWR_ON    = 3'b001,
        PWR_ARMED = 3'b010,
        PWR_DOWN  = 3'b100
    } spl_pwr_e;

endpackage : spl_pkg

//--- design/spl_word_if.sv
`timescale 1ns/10ps
// Carries a received word and its one-cycle transfer pulse
interface spl_word_if;
    logic [23:0] word;
    logic        load;
    modport src (output word, output load);
    modport dst (input word, input load);
endinterface : spl_word_if

//--- design/spl_serial_in.sv
`timescale 1ns/10ps
module spl_serial_in
(
    input  wire logic   i_mclk,
    input  wire logic   i_rst_n,
    input  wire logic   i_sclk,
    input  wire logic   i_sdata,
    input  wire logic   i_latch_load_strobe,
    spl_word_if.src     wif
);

    // ------------------------------------------------------------
    // Edge detection on the sampled serial pins
    // ------------------------------------------------------------
    logic        sclk_q;
    logic        le_q;
    logic [23:0] shift;

    // Previous pin levels; pins are synchronous to i_mclk
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            sclk_q <= 1'b0;
            le_q   <= 1'b0;
        end
        else
        begin
            sclk_q <= i_sclk;
            le_q   <= i_latch_load_strobe;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
            shift <= 24'h000000;
        else if (i_sclk && !sclk_q)
            shift <= {shift[22:0], i_sdata};
    end

    // Strobe rise transfers word
    // Never gated by power state, so loading works while powered down
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            wif.word <= 24'h000000;
            wif.load <= 1'b0;
        end
        else
        begin
            wif.load <= i_latch_load_strobe && !le_q;
            if (i_latch_load_strobe && !le_q)
                wif.word <= shift;
        end
    end

endmodule : spl_serial_in

//--- dv/spl_host_model.sv
`timescale 1ns/10ps
// Host side of the three-wire port; serial clock idles low between words
module spl_host_model
(
    input  wire logic i_mclk,
    output logic      o_sclk,
    output logic      o_sdata,
    output logic      o_strobe
);
    initial
    begin
        o_sclk   = 1'b0;
        o_sdata  = 1'b0;
        o_strobe = 1'b0;
    end

    // whole word, top bit first, strobe after
    task send(input logic [23:0] w);
        for (int i = 23; i >= 0; i--)
        begin
            @(posedge i_mclk);
            #1 o_sclk = 1'b0;
            o_sdata = w[i];
            @(posedge i_mclk);
            #1 o_sclk = 1'b1;
        end
        @(posedge i_mclk);
        #1 o_sclk = 1'b0;
        // Released data line flips, so a stale bit never looks valid
        o_sdata  = ~o_sdata;
        o_strobe = 1'b1;
        repeat (2) @(posedge i_mclk);
        #1 o_strobe = 1'b0;
        repeat (3) @(posedge i_mclk);
    endtask : send
endmodule : spl_host_model

//--- dv/testbench.sv
`timescale 1ns/10ps
module testbench;
    localparam logic [23:0] REF_W = (24'h1 << spl_pkg::RF_LOCK_PREC)
        | (24'h2 << spl_pkg::RF_ABP_LSB) | (24'h5 << spl_pkg::RF_DIV_LSB)
        | spl_pkg::SEL_REFERENCE;
    localparam logic [23:0] FB_W = (24'hA << spl_pkg::FB_MAIN_LSB)
        | (24'h3 << spl_pkg::FB_SWALLOW_LSB) | spl_pkg::SEL_FEEDBACK;

    logic        mclk    = 1'b0;
    logic        rst_n   = 1'b0;
    logic        chip_en = 1'b1;
    logic        ref_in  = 1'b0;
    logic        vco_in  = 1'b0;
    logic        sclk, sdata, strobe;
    logic        pd, tri_st, gain, pol, rf_en, rbuf, lock, halv, psrc;
    logic        ref_o, fb_o, band;
    logic [2:0]  code, mux;
    logic [1:0]  abp, plvl, core_lvl;
    logic [18:0] ratio;
    int          fail_count = 0;
    int          tests_run  = 0;

    // ------------------------------------------------------------
    // Clock, stimulus and instances
    // ------------------------------------------------------------
    always #10 mclk = ~mclk;

    // Free-running reference and oscillator, toggled just after the edge
    always @(posedge mclk)
    begin
        ref_in <= #1 ~ref_in;
        vco_in <= #1 ~vco_in;
    end

    spl_host_model i_spl_host_model
    (
        .i_mclk   (mclk),
        .o_sclk   (sclk),
        .o_sdata  (sdata),
        .o_strobe (strobe)
    );

    spl_program_latches i_spl_program_latches
    (
        .i_mclk (mclk), .i_rst_n (rst_n), .i_sclk (sclk), .i_sdata (sdata),
        .i_latch_load_strobe (strobe), .i_chip_en (chip_en),
        .i_ref_in (ref_in), .i_vco_in (vco_in), .o_powered_down (pd),
        .o_pump_tristate (tri_st), .o_pump_gain_set2 (gain),
        .o_pump_current_code (code), .o_detector_polarity (pol),
        .o_rf_enable (rf_en), .o_ref_buffer_en (rbuf), .o_lock (lock),
        .o_halver_en (halv), .o_presc_src_halved (psrc), .o_ref_out (ref_o),
        .o_fb_out (fb_o), .o_band_tick (band), .o_feedback_ratio (ratio),
        .o_output_power_level (plvl), .o_core_current_level (core_lvl),
        .o_status_mux_select (mux), .o_antibacklash_width (abp)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task check(input string n, input logic [18:0] s, input logic [18:0] e);
        tests_run++;
        if (s !== e)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask : check

    // Let the last edge's updates land before looking
    task wr(input logic [23:0] w);
        i_spl_host_model.send(w);
        #2;
    endtask : wr

    task conclude;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : conclude

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task t_power_up;
        check("pd", pd, 0);
        check("lock", lock, 0);
        wr(REF_W);
        wr(24'h0);
        wr(FB_W);
        check("ratio", ratio, 19'h53);
        check("abp", abp, 2'h2);
    endtask : t_power_up

    task t_gain;
        wr((24'h1 << spl_pkg::CT_GAIN) | (24'h5 << spl_pkg::CT_CUR2_LSB)
            | (24'h2 << spl_pkg::CT_CUR1_LSB) | (24'h3 << spl_pkg::CT_PWR_LSB)
            | (24'h6 << spl_pkg::CT_MUX_LSB) | (24'h1 << spl_pkg::CT_CORE_LSB));
        check("plvl", plvl, 2'h3);
        check("mux", mux, 3'h6);
        check("core", core_lvl, 2'h1);
        check("gain", gain, 1);
        check("code2", code, 3'h5);
        wr(FB_W);
        check("gain_fb0", gain, 0);
        check("code1", code, 3'h2);
        wr(FB_W | (24'h1 << spl_pkg::FB_GAIN));
        check("gain_fb1", gain, 1);
    endtask : t_gain

    task t_misc;
        wr((24'h1 << spl_pkg::CT_PUMP_TRI) | (24'h1 << spl_pkg::CT_POL)
            | (24'h1 << spl_pkg::CT_MUTE));
        check("tri", tri_st, 1);
        check("pol", pol, 1);
        check("mute", rf_en, 0);
        wr(FB_W | (24'h3 << spl_pkg::FB_HALVER));
        check("halv", halv, 1);
        check("psrc", psrc, 1);
        wr(24'hFFFFFF);
        check("test_word", ratio, 19'h53);
        check("test_pol", pol, 1);
        wr(24'h0);
        check("rf_on", rf_en, 1);
    endtask : t_misc

    task t_async;
        wr(24'h1 << spl_pkg::CT_PD_ARM);
        check("pd", pd, 1);
        check("tri", tri_st, 1);
        check("rf", rf_en, 0);
        check("rbuf", rbuf, 0);
        wr((24'h3 << spl_pkg::FB_MAIN_LSB) | (24'h1F << spl_pkg::FB_SWALLOW_LSB)
            | spl_pkg::SEL_FEEDBACK);
        check("ratio_pd", ratio, 19'h37);
        wr(24'h0);
        check("pd_off", pd, 0);
    endtask : t_async

    task t_chip_en;
        @(posedge mclk);
        #1 chip_en = 1'b0;
        #1 check("ce", pd, 1);
        @(posedge mclk);
        #1 chip_en = 1'b1;
        #1 check("ce_up", pd, 0);
    endtask : t_chip_en

    task t_sync;
        wr((24'h1 << spl_pkg::CT_PD_ARM) | (24'h1 << spl_pkg::CT_PD_SYNC));
        check("sync_wait", pd, 0);
        for (int k = 0; k < 40 && pd !== 1'b1; k++)
        begin
            @(posedge mclk);
            #1;
        end
        check("sync_pd", pd, 1);
        wr(24'h0);
    endtask : t_sync

    // Equal ratios released together give a good edge every period
    task t_lock;
        int refs;
        int fbs;
        int ticks;
        refs    = 0;
        fbs     = 0;
        ticks   = 0;
        chip_en = 1'b0;
        wr(24'h040061);
        wr(24'h000302);
        wr(24'h000810);
        chip_en = 1'b1;
        for (int k = 0; k < 30; k++)
        begin
            @(posedge mclk);
            #1 refs += ref_o;
        end
        check("hold_refs", refs, 0);
        wr(24'h000800);
        check("mute_pre", rf_en, 0);
        for (int k = 0; k < 400 && lock !== 1'b1; k++)
        begin
            @(posedge mclk);
            #1 refs += ref_o;
            fbs   += fb_o;
            ticks += band;
        end
        check("lock", lock, 1);
        check("lock_refs", refs, spl_pkg::LOCK_CNT_FINE);
        check("fb_pulses", fbs, 5);
        check("band_ticks", ticks, 5);
        check("mute_post", rf_en, 1);
    endtask : t_lock

    // ------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------
    initial
    begin
        repeat (12) @(posedge mclk);
        #1 rst_n = 1'b1;
        t_power_up();
        t_gain();
        t_misc();
        t_async();
        t_chip_en();
        t_sync();
        t_lock();
        conclude();
    end

    initial
    begin
        repeat (20000) @(posedge mclk);
        fail_count++;
        conclude();
    end
endmodule : testbench
